// File: hw/ms_interval_timer.sv
// Millisecond up-counter that runs while enabled and flags reaching a limit
module ms_interval_timer #(
	parameter int CYC_PER_MS = prot_seq_pkg::MS_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [11:0] limit_ms,
	output logic [11:0] elapsed_ms,
	output logic expired
);
	initial begin
		if (CYC_PER_MS < 1 || CYC_PER_MS > 1048575) begin
			$error("ms_interval_timer: CYC_PER_MS out of range");
		end
	end

	logic [19:0] div_r;
	logic [11:0] ms_r;

	// Dropping run restarts from zero, so every wait is a full interval
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_r <= 20'h00000;
			ms_r <= 12'h000;
		end else if (!run) begin
			div_r <= 20'h00000;
			ms_r <= 12'h000;
		end else if (div_r == 20'(CYC_PER_MS - 1)) begin
			div_r <= 20'h00000;
			if (!expired) begin
				ms_r <= ms_r + 12'h001;
			end
		end else begin
			div_r <= div_r + 20'h00001;
		end
	end

	assign elapsed_ms = ms_r;
	assign expired = run && (ms_r >= limit_ms);
endmodule : ms_interval_timer

// File: hw/prot_first_picker.sv
// Picks the lowest-index active trigger among the protection requests
module prot_first_picker #(
	parameter int N = prot_seq_pkg::N_PROT
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [3:0] idx
);
	initial begin
		if (N < 1 || N > 16) begin
			$error("prot_first_picker: N must be 1 to 16");
		end
	end

	logic [N-1:0] lower_free;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_chain
			if (g == 0) begin : g_first
				assign lower_free[g] = 1'b1;
			end else begin : g_rest
				assign lower_free[g] = lower_free[g-1] && !req[g-1];
			end
		end
	endgenerate

	always_comb begin
		idx = 4'h0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i] && lower_free[i]) begin
				idx = 4'(i);
			end
		end
	end

	assign any = |req;
endmodule : prot_first_picker

// File: hw/prot_reaction_seq.sv
// Protection reaction sequencer with AHB-Lite configuration and status
//
// Design decisions made here: the register offsets and the AHB-Lite slave port.
module prot_reaction_seq #(
	parameter int CYC_PER_MS = prot_seq_pkg::MS_CYC,
	parameter int HALF_FIXED = prot_seq_pkg::HALF_FIXED_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire prot_seq_pkg::prot_in_s prot_in,
	input wire logic burst_operation,
	input wire logic line_sync_ok,
	input wire logic [19:0] line_period_cyc,
	input wire logic below_lower_lockout,
	input wire logic above_upper_lockout,
	input wire logic recharge_done,
	input wire logic precheck_ok,
	input wire logic startup_done,
	output logic gate_on,
	output logic discharge_pulse,
	output logic hv_cell_on,
	output logic latched,
	output logic stopped,
	output logic regulated
);
	initial begin
		if (HALF_FIXED < 512 || HALF_FIXED > 1048575) begin
			$error("prot_reaction_seq: HALF_FIXED out of range");
		end
	end

	prot_seq_pkg::ctrl_s ctrl_r;
	logic [11:0] restart_ms_r;
	logic [11:0] uv_blank_r;
	logic [15:0] pulse_w_r;
	logic [15:0] code_r;
	logic [19:0] half_r;
	prot_seq_pkg::state_e state_r, state_nxt;
	prot_seq_pkg::react_e react_r, react_sel;
	logic [15:0] pulse_cnt_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [8:0] req;
	logic any_req, running, accept;
	logic [3:0] pick_idx;
	logic uv_run, uv_expired, wait_run, wait_expired;
	logic [11:0] wait_limit, wait_ms;
	logic in_prot_ok;

	// Bus: zero wait state, always OKAY
	logic addr_ok;
	assign addr_ok = hsel && htrans[1] && hready;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	// Read data captured at the address phase edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (addr_ok && !hwrite) begin
			case ({haddr[7:2], 2'b00})
				prot_seq_pkg::REG_CTRL: hrdata <= {24'h000000, ctrl_r};
				prot_seq_pkg::REG_RESTART: hrdata <= {20'h00000, restart_ms_r};
				prot_seq_pkg::REG_UV_BLANK: hrdata <= {20'h00000, uv_blank_r};
				prot_seq_pkg::REG_PULSE: hrdata <= {16'h0000, pulse_w_r};
				prot_seq_pkg::REG_STATUS:
					hrdata <= {12'h000, state_r, code_r};
				prot_seq_pkg::REG_HALF: hrdata <= {12'h000, half_r};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Configuration writes; out-of-range times are clamped to the limits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= prot_seq_pkg::CTRL_RST;
			restart_ms_r <= prot_seq_pkg::RESTART_RST_MS;
			uv_blank_r <= prot_seq_pkg::UV_BLANK_RST_MS;
			pulse_w_r <= prot_seq_pkg::PULSE_RST_CYC;
		end else if (wr_pend_r) begin
			case ({wr_addr_r[7:2], 2'b00})
				prot_seq_pkg::REG_CTRL:
					ctrl_r <= hwdata[7:0];
				prot_seq_pkg::REG_RESTART:
					if (hwdata[11:0] < prot_seq_pkg::RESTART_MIN_MS)
						restart_ms_r <= prot_seq_pkg::RESTART_MIN_MS;
					else if (hwdata[11:0] > prot_seq_pkg::RESTART_MAX_MS
						|| hwdata[31:12] != 20'h00000)
						restart_ms_r <= prot_seq_pkg::RESTART_MAX_MS;
					else
						restart_ms_r <= hwdata[11:0];
				prot_seq_pkg::REG_UV_BLANK:
					if (hwdata[11:0] < prot_seq_pkg::UV_BLANK_MIN_MS)
						uv_blank_r <= prot_seq_pkg::UV_BLANK_MIN_MS;
					else if (hwdata[11:0] > prot_seq_pkg::UV_BLANK_MAX_MS
						|| hwdata[31:12] != 20'h00000)
						uv_blank_r <= prot_seq_pkg::UV_BLANK_MAX_MS;
					else
						uv_blank_r <= hwdata[11:0];
				prot_seq_pkg::REG_PULSE:
					pulse_w_r <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
				default: ;
			endcase
		end
	end

	// Timing base: measured period only once line sync holds
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			half_r <= 20'(HALF_FIXED);
		end else begin
			half_r <= line_sync_ok ? line_period_cyc : 20'(HALF_FIXED);
		end
	end

	// Trigger qualification
	assign running = (state_r == prot_seq_pkg::ST_PRECHECK)
		|| (state_r == prot_seq_pkg::ST_STARTUP)
		|| (state_r == prot_seq_pkg::ST_REGULATED);
	assign in_prot_ok = !burst_operation
		|| ctrl_r.burst_input_protect_enable;
	assign uv_run = prot_in.output_uv_raw && ctrl_r.output_uv_enable
		&& (state_r == prot_seq_pkg::ST_REGULATED);

	ms_interval_timer #(.CYC_PER_MS(CYC_PER_MS)) u_uv_blank (
		.clk(clk),
		.rst(rst),
		.run(uv_run),
		.limit_ms(uv_blank_r),
		.elapsed_ms(),
		.expired(uv_expired)
	);

	always_comb begin
		req = 9'h000;
		req[prot_seq_pkg::P_OUT_OV] = prot_in.output_ov;
		req[prot_seq_pkg::P_OUT_UV] = uv_expired;
		req[prot_seq_pkg::P_SUP_OV] = prot_in.supply_ov;
		req[prot_seq_pkg::P_IN_UV] = prot_in.input_uv
			&& ctrl_r.input_uv_enable && in_prot_ok;
		req[prot_seq_pkg::P_IN_OV] = prot_in.input_ov
			&& ctrl_r.input_ov_enable && in_prot_ok;
		req[prot_seq_pkg::P_MISC] = prot_in.misc_auto;
		req[prot_seq_pkg::P_ADC_WD] = prot_in.adc_watchdog;
		req[prot_seq_pkg::P_CRC] = prot_in.crc_fail;
		req[prot_seq_pkg::P_EMPTY] = prot_in.param_store_empty;
	end

	prot_first_picker #(.N(prot_seq_pkg::N_PROT)) u_pick (
		.req(req),
		.any(any_req),
		.idx(pick_idx)
	);

	// Later triggers are ignored outside the running states
	assign accept = running && any_req;

	always_comb begin
		case (pick_idx)
			4'h0: react_sel = ctrl_r.output_ov_reaction_select ?
				prot_seq_pkg::REACT_LATCH : prot_seq_pkg::REACT_AUTO;
			4'h1: react_sel = ctrl_r.output_uv_reaction_select ?
				prot_seq_pkg::REACT_LATCH : prot_seq_pkg::REACT_AUTO;
			4'h2: react_sel = ctrl_r.supply_ov_reaction_select ?
				prot_seq_pkg::REACT_LATCH : prot_seq_pkg::REACT_AUTO;
			4'h6: react_sel = prot_seq_pkg::REACT_FAST;
			4'h7: react_sel = prot_seq_pkg::REACT_STOP;
			4'h8: react_sel = prot_seq_pkg::REACT_STOP;
			default: react_sel = prot_seq_pkg::REACT_AUTO;
		endcase
		// Supply lockout acts as reset, so debug never reaches it
		if (ctrl_r.debug_stop_mode) begin
			react_sel = prot_seq_pkg::REACT_STOP;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			react_r <= prot_seq_pkg::REACT_AUTO;
			code_r <= 16'h0000;
		end else if (accept) begin
			react_r <= react_sel;
			code_r <= prot_seq_pkg::prot_code(pick_idx);
		end
	end

	// Restart wait
	assign wait_run = (state_r == prot_seq_pkg::ST_WAIT);
	assign wait_limit = (react_r == prot_seq_pkg::REACT_FAST) ?
		12'(prot_seq_pkg::FAST_RESTART_MS) : restart_ms_r;

	ms_interval_timer #(.CYC_PER_MS(CYC_PER_MS)) u_wait (
		.clk(clk),
		.rst(rst),
		.run(wait_run),
		.limit_ms(wait_limit),
		.elapsed_ms(wait_ms),
		.expired(wait_expired)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			prot_seq_pkg::ST_PRECHECK:
				if (accept) state_nxt = prot_seq_pkg::ST_SHUTDOWN;
				else if (precheck_ok) state_nxt = prot_seq_pkg::ST_STARTUP;
			prot_seq_pkg::ST_STARTUP:
				if (accept) state_nxt = prot_seq_pkg::ST_SHUTDOWN;
				else if (startup_done) state_nxt = prot_seq_pkg::ST_REGULATED;
			prot_seq_pkg::ST_REGULATED:
				if (accept) state_nxt = prot_seq_pkg::ST_SHUTDOWN;
			prot_seq_pkg::ST_SHUTDOWN:
				case (react_r)
					prot_seq_pkg::REACT_LATCH: state_nxt = prot_seq_pkg::ST_LATCH;
					prot_seq_pkg::REACT_STOP: state_nxt = prot_seq_pkg::ST_STOP;
					default: state_nxt = prot_seq_pkg::ST_WAIT;
				endcase
			prot_seq_pkg::ST_WAIT:
				if (wait_expired) state_nxt = prot_seq_pkg::ST_PULSE;
			prot_seq_pkg::ST_PULSE:
				if (pulse_cnt_r == pulse_w_r - 16'h0001)
					state_nxt = prot_seq_pkg::ST_RECHARGE;
			prot_seq_pkg::ST_RECHARGE:
				if (recharge_done) state_nxt = prot_seq_pkg::ST_PRECHECK;
			prot_seq_pkg::ST_LATCH: state_nxt = prot_seq_pkg::ST_LATCH;
			prot_seq_pkg::ST_STOP: state_nxt = prot_seq_pkg::ST_STOP;
			default: state_nxt = prot_seq_pkg::ST_SHUTDOWN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= prot_seq_pkg::ST_PRECHECK;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse_cnt_r <= 16'h0000;
		end else if (state_r == prot_seq_pkg::ST_PULSE) begin
			pulse_cnt_r <= pulse_cnt_r + 16'h0001;
		end else begin
			pulse_cnt_r <= 16'h0000;
		end
	end

	// Outputs follow the next state so the gate drops at the accept edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_on <= 1'b0;
			discharge_pulse <= 1'b0;
			latched <= 1'b0;
			stopped <= 1'b0;
			regulated <= 1'b0;
		end else begin
			gate_on <= (state_nxt == prot_seq_pkg::ST_PRECHECK)
				|| (state_nxt == prot_seq_pkg::ST_STARTUP)
				|| (state_nxt == prot_seq_pkg::ST_REGULATED);
			discharge_pulse <= (state_nxt == prot_seq_pkg::ST_PULSE);
			latched <= (state_nxt == prot_seq_pkg::ST_LATCH);
			stopped <= (state_nxt == prot_seq_pkg::ST_STOP);
			regulated <= (state_nxt == prot_seq_pkg::ST_REGULATED);
		end
	end

	// HV cell hysteresis during holds; plain charge during recharge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hv_cell_on <= 1'b0;
		end else if (state_r == prot_seq_pkg::ST_LATCH
			|| state_r == prot_seq_pkg::ST_WAIT
			|| state_r == prot_seq_pkg::ST_PULSE) begin
			if (below_lower_lockout) hv_cell_on <= 1'b1;
			else if (above_upper_lockout) hv_cell_on <= 1'b0;
		end else if (state_r == prot_seq_pkg::ST_RECHARGE) begin
			hv_cell_on <= !recharge_done;
		end else begin
			hv_cell_on <= 1'b0;
		end
	end

	// Checks
	logic seen_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) seen_r <= 1'b0;
		else if (accept) seen_r <= 1'b1;
	end

	a_gate_off_fast: assert property (@(posedge clk) disable iff (rst)
		accept |=> !gate_on && (half_r >> prot_seq_pkg::GATE_OFF_DIV_LOG2) >= 20'h1)
		else $error("gate not off after trigger");
	a_half_period_sel: assert property (@(posedge clk) disable iff (rst)
		##1 half_r == ($past(line_sync_ok) ? $past(line_period_cyc) : 20'(HALF_FIXED)))
		else $error("half period base wrong");
	a_latch_holds: assert property (@(posedge clk) disable iff (rst)
		state_r == prot_seq_pkg::ST_LATCH |=> (latched && !gate_on) [*8])
		else $error("latch left or gate on");
	a_wait_length: assert property (@(posedge clk) disable iff (rst)
		(wait_run && state_nxt != prot_seq_pkg::ST_WAIT) |-> wait_ms == wait_limit)
		else $error("restart wait length wrong");
	a_hv_low_on: assert property (@(posedge clk) disable iff (rst)
		(wait_run && below_lower_lockout) |=> hv_cell_on)
		else $error("hv cell not on below lockout");
	a_stop_holds: assert property (@(posedge clk) disable iff (rst)
		state_r == prot_seq_pkg::ST_STOP |=> stopped && !hv_cell_on && !gate_on)
		else $error("stop state left");
	a_pulse_width: assert property (@(posedge clk) disable iff (rst)
		$fell(discharge_pulse) |-> $past(pulse_cnt_r) == pulse_w_r - 16'h0001)
		else $error("discharge pulse width wrong");
	a_recharge_wait: assert property (@(posedge clk) disable iff (rst)
		(state_r == prot_seq_pkg::ST_RECHARGE && !recharge_done)
		|=> !gate_on && state_r == prot_seq_pkg::ST_RECHARGE)
		else $error("recharge skipped");
	a_startup_gate: assert property (@(posedge clk) disable iff (rst)
		(state_r == prot_seq_pkg::ST_PRECHECK && !accept && precheck_ok)
		|=> state_r == prot_seq_pkg::ST_STARTUP && gate_on)
		else $error("precheck pass not followed");
	a_rerun_fault: assert property (@(posedge clk) disable iff (rst)
		accept |=> state_r == prot_seq_pkg::ST_SHUTDOWN ##1 !gate_on)
		else $error("fault did not restart sequence");
	a_debug_stop: assert property (@(posedge clk) disable iff (rst)
		(accept && ctrl_r.debug_stop_mode) |=> ##1 state_r == prot_seq_pkg::ST_STOP)
		else $error("debug did not force stop");
	a_code_in_uv: assert property (@(posedge clk) disable iff (rst)
		(accept && pick_idx == 4'(prot_seq_pkg::P_IN_UV)) |=> code_r == 16'h0040)
		else $error("input uv code wrong");
	a_code_idle: assert property (@(posedge clk) disable iff (rst)
		!seen_r |-> code_r == 16'h0000)
		else $error("code nonzero before trigger");
	a_empty_stop: assert property (@(posedge clk) disable iff (rst)
		(accept && pick_idx == 4'(prot_seq_pkg::P_EMPTY))
		|=> ##1 state_r == prot_seq_pkg::ST_STOP)
		else $error("empty store not stop");

	c_auto_restart: cover property (@(posedge clk) disable iff (rst)
		state_r == prot_seq_pkg::ST_RECHARGE ##1 state_r == prot_seq_pkg::ST_PRECHECK);
	c_latch: cover property (@(posedge clk) disable iff (rst)
		state_r == prot_seq_pkg::ST_LATCH);
	c_regulated: cover property (@(posedge clk) disable iff (rst)
		regulated ##1 accept);
endmodule : prot_reaction_seq

// File: hw/prot_seq_pkg.sv
// Constants, types and register map of the protection reaction sequencer
// What this block does
// - Gate off within 1/512 half period
// - Half period fixed or measured, by sync
// - Latch holds until supply off reset
// - Auto-restart waits configured restart delay
// - Fast auto-restart waits fixed 0.4 s
// - HV cell keeps supply between lockouts
// - Stop never restarts by itself
// - One discharge pulse of configured width
// - Wait for supply recharge, open length
// - Precheck with gate on, then startup, regulated
// - Fault while running restarts whole sequence
// - Debug forces stop, except supply lockout
// - Status code shows last protection, 0040 input UV
// - Status code 0000 when nothing triggered
// - Output OV reaction selectable auto or latch
// - Output UV own enable, selectable reaction
// - Output UV blanking 5 to 1000 ms
// - Supply OV reaction selectable latch or auto
// - Separate input OV and UV enables
// - Enable gates input protections in burst
// - Empty parameter store raises stop protection
package prot_seq_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int HALF_FIXED_NS = 9823000;
	localparam int HALF_FIXED_CYC = HALF_FIXED_NS / (1000000000 / CLK_HZ);
	localparam int MS_CYC = CLK_HZ / 1000;
	localparam int FAST_RESTART_MS = 400;
	localparam int GATE_OFF_DIV_LOG2 = 9;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RESTART = 8'h04;
	localparam logic [7:0] REG_UV_BLANK = 8'h08;
	localparam logic [7:0] REG_PULSE = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_HALF = 8'h14;

	localparam logic [11:0] RESTART_MIN_MS = 12'h190;
	localparam logic [11:0] RESTART_MAX_MS = 12'hFA0;
	localparam logic [11:0] RESTART_RST_MS = 12'h4B0;
	localparam logic [11:0] UV_BLANK_MIN_MS = 12'h005;
	localparam logic [11:0] UV_BLANK_MAX_MS = 12'h3E8;
	localparam logic [11:0] UV_BLANK_RST_MS = 12'h1F4;
	localparam logic [15:0] PULSE_RST_CYC = 16'h0032;

	// Trigger source indices; lower index wins on a tie
	localparam int N_PROT = 9;
	localparam int P_OUT_OV = 0;
	localparam int P_OUT_UV = 1;
	localparam int P_SUP_OV = 2;
	localparam int P_IN_UV = 3;
	localparam int P_IN_OV = 4;
	localparam int P_MISC = 5;
	localparam int P_ADC_WD = 6;
	localparam int P_CRC = 7;
	localparam int P_EMPTY = 8;

	typedef enum logic [1:0] {
		REACT_LATCH, REACT_AUTO, REACT_FAST, REACT_STOP
	} react_e;

	typedef enum logic [3:0] {
		ST_PRECHECK, ST_STARTUP, ST_REGULATED, ST_SHUTDOWN, ST_LATCH,
		ST_WAIT, ST_PULSE, ST_RECHARGE, ST_STOP
	} state_e;

	typedef struct packed {
		logic burst_input_protect_enable;
		logic input_uv_enable;
		logic input_ov_enable;
		logic supply_ov_reaction_select;
		logic output_uv_reaction_select;
		logic output_uv_enable;
		logic output_ov_reaction_select;
		logic debug_stop_mode;
	} ctrl_s;

	// Latch select bits are 1 for latch, 0 for auto-restart
	localparam ctrl_s CTRL_RST = 8'hF4;

	typedef struct packed {
		logic param_store_empty;
		logic crc_fail;
		logic adc_watchdog;
		logic misc_auto;
		logic input_ov;
		logic input_uv;
		logic supply_ov;
		logic output_uv_raw;
		logic output_ov;
	} prot_in_s;

	function automatic logic [15:0] prot_code(input logic [3:0] idx);
		case (idx)
			4'h0: prot_code = 16'h0010;
			4'h1: prot_code = 16'h0020;
			4'h2: prot_code = 16'h0030;
			4'h3: prot_code = 16'h0040;
			4'h4: prot_code = 16'h0041;
			4'h5: prot_code = 16'h0050;
			4'h6: prot_code = 16'h0060;
			4'h7: prot_code = 16'h0070;
			default: prot_code = 16'h0080;
		endcase
	endfunction : prot_code
endpackage : prot_seq_pkg

// File: tb/flyback_stage_model.sv
// Behavioural power stage and supply model facing the sequencer
module flyback_stage_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic gate_on,
	input wire logic discharge_pulse,
	input wire logic hv_cell_on,
	output logic below_lower_lockout,
	output logic above_upper_lockout,
	output logic recharge_done,
	output logic precheck_ok,
	output logic startup_done
);
	timeunit 1ns;
	timeprecision 1ps;
	int vcc_r;
	int run_r;
	int chg_r;
	// Aux winding holds the supply while switching
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vcc_r <= 50;
			run_r <= 0;
			chg_r <= 0;
		end else begin
			if (hv_cell_on) begin
				vcc_r <= vcc_r + 1;
			end else if (!gate_on) begin
				vcc_r <= vcc_r - 1;
			end
			run_r <= gate_on ? run_r + 1 : 0;
			chg_r <= discharge_pulse ? 0 : chg_r + int'(hv_cell_on);
		end
	end
	assign below_lower_lockout = vcc_r < 20;
	assign above_upper_lockout = vcc_r > 80;
	// Recharge is slow on purpose: 20 cycles of cell current
	assign recharge_done = chg_r >= 20;
	assign precheck_ok = run_r >= 3;
	assign startup_done = run_r >= 8;
endmodule : flyback_stage_model

// File: tb/prot_reaction_seq_tb.sv
// Self-checking bench for the protection reaction sequencer
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
$display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module prot_reaction_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, q, hrdata;
	prot_seq_pkg::prot_in_s prot_in;
	logic hreadyout, hresp, gate_on, discharge_pulse, hv_cell_on;
	logic latched, stopped, regulated, below_lo, above_hi;
	logic recharge_done, precheck_ok, startup_done;
	logic line_sync, burst;
	int fails = 0;
	int samples_checked = 0;

	prot_reaction_seq #(.CYC_PER_MS(10), .HALF_FIXED(1024)) u_dut (
		.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.prot_in(prot_in), .burst_operation(burst), .line_sync_ok(line_sync),
		.line_period_cyc(20'h00800), .below_lower_lockout(below_lo),
		.above_upper_lockout(above_hi), .recharge_done(recharge_done),
		.precheck_ok(precheck_ok), .startup_done(startup_done),
		.gate_on(gate_on), .discharge_pulse(discharge_pulse),
		.hv_cell_on(hv_cell_on), .latched(latched), .stopped(stopped),
		.regulated(regulated)
	);

	flyback_stage_model u_stage (
		.clk(clk), .rst(rst), .gate_on(gate_on),
		.discharge_pulse(discharge_pulse), .hv_cell_on(hv_cell_on),
		.below_lower_lockout(below_lo), .above_upper_lockout(above_hi),
		.recharge_done(recharge_done), .precheck_ok(precheck_ok),
		.startup_done(startup_done)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : ahb

	task automatic trigger(input int src, input int hold);
		@(posedge clk);
		prot_in <= prot_seq_pkg::prot_in_s'(9'h001 << src);
		repeat (hold) @(posedge clk);
		prot_in <= '0;
		#1;
	endtask : trigger

	task automatic reg_check();
		logic [7:0] a [5];
		logic [31:0] e [5];
		a = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
		e = '{32'hF4, 32'h4B0, 32'h1F4, 32'h32, 32'h0};
		for (int i = 0; i < 5; i++) begin
			ahb(1'b0, a[i], 32'h0);
			`CHK(q, e[i])
		end
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(q[15:0], 16'h0000)
		`CHK(hresp, 1'b0)
		ahb(1'b1, 8'h04, 32'h1);
		ahb(1'b0, 8'h04, 32'h0);
		`CHK(q, 32'h190)
		ahb(1'b1, 8'h08, 32'h2);
		ahb(1'b0, 8'h08, 32'h0);
		`CHK(q, 32'h5)
		ahb(1'b0, 8'h14, 32'h0);
		`CHK(q, 32'h400)
		line_sync <= 1'b1;
		ahb(1'b0, 8'h14, 32'h0);
		`CHK(q, 32'h800)
		line_sync <= 1'b0;
		$display("test registers done");
	endtask : reg_check

	task automatic burst_run();
		burst <= 1'b1;
		ahb(1'b1, 8'h00, 32'h74);
		trigger(3, 3);
		`CHK(gate_on, 1'b1)
		burst <= 1'b0;
		ahb(1'b1, 8'h00, 32'hF4);
		$display("test burst done");
	endtask : burst_run

	task automatic restart_run(input int src, input logic [15:0] code,
		input int ms);
		time t0;
		int w;
		trigger(src, 1);
		t0 = $time;
		`CHK(gate_on, 1'b0)
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(q[15:0], code)
		while (discharge_pulse !== 1'b1 && $time - t0 < 200000)
			@(posedge clk) #1;
		w = int'(($time - t0) / 20);
		`CHK((w >= ms * 10 && w <= ms * 10 + 8), 1'b1)
		w = 0;
		while (discharge_pulse === 1'b1 && w < 100) begin
			@(posedge clk) #1;
			w++;
		end
		`CHK(w, 5)
		t0 = $time;
		while (gate_on !== 1'b1 && $time - t0 < 20000) @(posedge clk) #1;
		`CHK(($time - t0 >= 400), 1'b1)
		while (regulated !== 1'b1 && $time - t0 < 40000) @(posedge clk) #1;
		`CHK(regulated, 1'b1)
		$display("test restart %0d done", src);
	endtask : restart_run

	task automatic hold_check(input logic exp_hv, output int hv_n,
		output int bad);
		hv_n = 0;
		bad = 0;
		repeat (600) begin
			@(posedge clk) #1;
			hv_n += int'(hv_cell_on === 1'b1);
			bad += int'(gate_on !== 1'b0 || discharge_pulse !== 1'b0
				|| (!exp_hv && hv_cell_on !== 1'b0));
		end
	endtask : hold_check

	task automatic latch_run();
		int hv_n;
		int bad;
		trigger(2, 5);
		`CHK(latched, 1'b1)
		hold_check(1'b1, hv_n, bad);
		`CHK((hv_n > 0 && hv_n < 600), 1'b1)
		`CHK(bad, 0)
		$display("test latch done");
	endtask : latch_run

	task automatic stop_run(input int src, input logic [7:0] ctl,
		input logic [19:0] st);
		int hv_n;
		int bad;
		@(posedge clk);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (20) @(posedge clk);
		// Debug switch belongs to bench setup only
		ahb(1'b1, 8'h00, {24'h000000, ctl});
		trigger(src, 5);
		`CHK(stopped, 1'b1)
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(q[19:0], st)
		hold_check(1'b0, hv_n, bad);
		`CHK(bad + hv_n, 0)
		`CHK(stopped, 1'b1)
		$display("test stop done");
	endtask : stop_run

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		prot_in = '0;
		line_sync = 1'b0;
		burst = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		reg_check();
		ahb(1'b1, 8'h04, 32'h258);
		ahb(1'b1, 8'h0C, 32'h5);
		repeat (20) @(posedge clk);
		burst_run();
		restart_run(0, 16'h0010, 600);
		restart_run(6, 16'h0060, 400);
		latch_run();
		stop_run(8, 8'hF4, 20'h80080);
		stop_run(3, 8'hF5, 20'h80040);
		end_of_test();
	end

	initial begin
		#1ms;
		fails++;
		end_of_test();
	end
endmodule : prot_reaction_seq_tb
